//--- logic/mix_mmd_indirect.v
//Behaviour
//R01: Device-select field routes every indirect data access to that MMD.
//R02: Indirect data reaches the MMD address register or addressed register, per control.
//R03: Extended status register is read-only; writes change nothing.
//R04: Status bit 15 reports 1000BASE-X full-duplex support.
//R05: Status bit 14 reports 1000BASE-X half-duplex support.
//R06: Status bit 13 reports 1000BASE-T full-duplex support.
//R07: Status bit 12 reports 1000BASE-T half-duplex support.
//R08: Controller writes zero to control reserved bits and ignores them on read.
//R09: Controller ignores reserved bits of the extended status register.
//R10: Access type 00 reaches the selected MMD's own address register.
//R11: Each MMD keeps its own address register, untouched by device switching.
//R12: Post-increment-all advances the address after every data read or write.
//R13: Post-increment-write advances the address after writes only, not reads.
//R14: Plain data access leaves the MMD address register unchanged.
//R15: Capabilities fixed: 1000BASE-T both supported, 1000BASE-X both unsupported.
`timescale 1ns/1ps
`default_nettype none
module mix_mmd_indirect
(
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   // Management register port, same clock domain
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [4:0]  reg_addr_in,
   input  wire [15:0] reg_wdata_in,
   output reg  [15:0] reg_rdata_out,
   output reg         reg_rvalid_out,
   // MMD register space side
   output reg         mmd_wr_out,
   output reg         mmd_rd_out,
   output reg  [4:0]  mmd_device_select_out,
   output reg  [15:0] mmd_reg_addr_out,
   output reg  [15:0] mmd_wdata_out,
   input  wire [15:0] mmd_rdata_in
);
`include "mix_regs.vh"

   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]  indirect_access_type_r;
   reg  [4:0]  mmd_device_select_r;
   wire [15:0] addr_bank [0:`MIX_NUM_DEV-1];
   wire [15:0] cur_addr;
   wire        wr_ctrl;
   wire        wr_data;
   wire        rd_data;
   wire        is_addr_acc;
   wire        do_inc;
   wire [15:0] ctrl_view;
   // Extended status image and its capability bits
   wire [15:0] xstat_view;
   wire        cap_1000x_full;
   wire        cap_1000x_half;
   wire        cap_1000t_full;
   wire        cap_1000t_half;
   // Next values, worked out in the combinational blocks below
   reg  [1:0]  indirect_access_type_nxt;
   reg  [4:0]  mmd_device_select_nxt;
   reg         mmd_wr_nxt;
   reg         mmd_rd_nxt;
   reg  [4:0]  mmd_dev_nxt;
   reg  [15:0] mmd_addr_nxt;
   reg  [15:0] mmd_wdata_nxt;
   reg  [15:0] rdata_nxt;
   reg         rvalid_nxt;

   // Reset image of the control register, cut into its fields
   localparam [15:0] CTRL_RESET = `MIX_CTRL_RESET;
   localparam [1:0]  TYPE_RESET = CTRL_RESET[`MIX_CTRL_TYPE_HI:`MIX_CTRL_TYPE_LO];
   localparam [4:0]  DEV_RESET  = CTRL_RESET[`MIX_CTRL_DEV_HI:`MIX_CTRL_DEV_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Register decode; a read and a write in one cycle are not expected
   assign wr_ctrl     = reg_wr_in && (reg_addr_in == `MIX_OFS_CTRL);
   assign wr_data     = reg_wr_in && (reg_addr_in == `MIX_OFS_DATA);
   assign rd_data     = reg_rd_in && (reg_addr_in == `MIX_OFS_DATA);
   assign is_addr_acc = (indirect_access_type_r == `MIX_TYPE_ADDRESS); // R10
   assign cur_addr    = addr_bank[mmd_device_select_r]; // R01
   // Increment after the access completes; plain data never moves it
   assign do_inc = ((indirect_access_type_r == `MIX_TYPE_PI_ALL) && (wr_data || rd_data)) // R12
                || ((indirect_access_type_r == `MIX_TYPE_PI_WR) && wr_data); // R13 R14
   // Reserved bits read back as zero
   assign ctrl_view = {indirect_access_type_r, 9'h000, mmd_device_select_r};

   ////////////////////////////////////////////////////////////////////////////
   // Extended status image; capabilities are fixed, software cannot change them
   assign cap_1000x_full = `MIX_CAP_1000X_FULL; // R04 R15
   assign cap_1000x_half = `MIX_CAP_1000X_HALF; // R05 R15
   assign cap_1000t_full = `MIX_CAP_1000T_FULL; // R06 R15
   assign cap_1000t_half = `MIX_CAP_1000T_HALF; // R07 R15
   // Reserved ranges read as zero; the controller ignores them anyway
   assign xstat_view = {cap_1000x_full, cap_1000x_half, cap_1000t_full, cap_1000t_half, 12'h000};

   ////////////////////////////////////////////////////////////////////////////
   // Control register; reserved bits are not stored, which saves nine flops
   always @*
   begin
      indirect_access_type_nxt = indirect_access_type_r;
      mmd_device_select_nxt    = mmd_device_select_r;
      if (wr_ctrl)
      begin
         indirect_access_type_nxt = reg_wdata_in[`MIX_CTRL_TYPE_HI:`MIX_CTRL_TYPE_LO];
         mmd_device_select_nxt    = reg_wdata_in[`MIX_CTRL_DEV_HI:`MIX_CTRL_DEV_LO]; // R01
      end
   end

   // Control fields take their next values
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         indirect_access_type_r <= TYPE_RESET;
         mmd_device_select_r    <= DEV_RESET;
      end
      else
      begin
         indirect_access_type_r <= indirect_access_type_nxt;
         mmd_device_select_r    <= mmd_device_select_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One address register per MMD
   genvar g;
   generate
      for (g = 0; g < `MIX_NUM_DEV; g = g + 1)
      begin : g_addr
         mix_mmd_addr u_addr
         (
            .clk_sys_in (clk_sys_in),
            .rst_n_in   (rst_n_in),
            .sel_in     (mmd_device_select_r == g), // R11
            .load_in    (wr_data && is_addr_acc), // R02 R10
            .inc_in     (do_inc),
            .wdata_in   (reg_wdata_in),
            .addr_out   (addr_bank[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Data accesses go out to the MMD space as one-cycle strobes
   always @*
   begin
      mmd_wr_nxt    = wr_data && !is_addr_acc; // R02
      mmd_rd_nxt    = rd_data && !is_addr_acc;
      mmd_dev_nxt   = mmd_device_select_out;
      mmd_addr_nxt  = mmd_reg_addr_out;
      mmd_wdata_nxt = mmd_wdata_out;
      // Address and data hold between accesses so the MMD side may sample late
      if ((wr_data || rd_data) && !is_addr_acc)
      begin
         mmd_dev_nxt   = mmd_device_select_r; // R01
         mmd_addr_nxt  = cur_addr; // Address before increment
         mmd_wdata_nxt = reg_wdata_in;
      end
   end

   // MMD-side outputs straight from flip-flops
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         mmd_wr_out            <= 1'b0;
         mmd_rd_out            <= 1'b0;
         mmd_device_select_out <= 5'h00;
         mmd_reg_addr_out      <= 16'h0000;
         mmd_wdata_out         <= `MIX_DATA_RESET;
      end
      else
      begin
         mmd_wr_out            <= mmd_wr_nxt;
         mmd_rd_out            <= mmd_rd_nxt;
         mmd_device_select_out <= mmd_dev_nxt;
         mmd_reg_addr_out      <= mmd_addr_nxt;
         mmd_wdata_out         <= mmd_wdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; extended status is a constant, so writes to it do nothing
   always @*
   begin
      rvalid_nxt = reg_rd_in;
      rdata_nxt  = reg_rdata_out;
      // Read data holds until the next read, so a slow master may pick it up late
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            `MIX_OFS_CTRL  : rdata_nxt = ctrl_view;
            `MIX_OFS_DATA  : rdata_nxt = is_addr_acc ? cur_addr : mmd_rdata_in; // R02
            `MIX_OFS_XSTAT : rdata_nxt = xstat_view; // R03 R04 R05 R06 R07 R15
            default        : rdata_nxt = 16'h0000; // Unmapped offsets read zero
         endcase
      end
   end

   // Registered answer, one cycle after the read strobe
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rdata_out  <= rdata_nxt;
         reg_rvalid_out <= rvalid_nxt;
      end
   end
endmodule
`default_nettype wire

//--- logic/mix_regs.vh
`ifndef MIX_REGS_VH
`define MIX_REGS_VH
// Register offsets on the management bus
`define MIX_OFS_CTRL        5'h0d
`define MIX_OFS_DATA        5'h0e
`define MIX_OFS_XSTAT       5'h0f
// Control register fields
`define MIX_CTRL_TYPE_HI    15
`define MIX_CTRL_TYPE_LO    14
`define MIX_CTRL_DEV_HI     4
`define MIX_CTRL_DEV_LO     0
// Access types
`define MIX_TYPE_ADDRESS    2'h0
`define MIX_TYPE_DATA       2'h1
`define MIX_TYPE_PI_ALL     2'h2
`define MIX_TYPE_PI_WR      2'h3
// Reset values
`define MIX_CTRL_RESET      16'h0000
`define MIX_DATA_RESET      16'h0000
`define MIX_XSTAT_VALUE     16'h3000
`define MIX_ADDR_RESET      16'h0000
// Fixed capability bits of the extended status register
`define MIX_CAP_1000X_FULL  1'b0
`define MIX_CAP_1000X_HALF  1'b0
`define MIX_CAP_1000T_FULL  1'b1
`define MIX_CAP_1000T_HALF  1'b1
// Number of device-select codes
`define MIX_NUM_DEV         32
`endif

//--- logic/mix_mmd_addr.v
`timescale 1ns/1ps
`default_nettype none
// One address register per MMD, with optional post-increment
module mix_mmd_addr
(
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        sel_in,
   input  wire        load_in,
   input  wire        inc_in,
   input  wire [15:0] wdata_in,
   output wire [15:0] addr_out
);
`include "mix_regs.vh"

   reg [15:0] addr_r;

   // Only the selected MMD moves; others keep their address
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         addr_r <= `MIX_ADDR_RESET;
      else if (sel_in && load_in)
         addr_r <= wdata_in;
      else if (sel_in && inc_in)
         addr_r <= addr_r + 16'h0001;
   end

   assign addr_out = addr_r;
endmodule
`default_nettype wire

//--- tb/mix_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the indirect access block
module mix_chk
(
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [4:0]  reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        reg_rvalid_out,
   input wire logic        mmd_wr_out,
   input wire logic        mmd_rd_out,
   input wire logic [15:0] mmd_wdata_out,
   input wire logic [15:0] mmd_rdata_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////
   // Answer timing and data sources
   a_rvalid_follows: assert property (reg_rvalid_out == $past(reg_rd_in)) else $error("rvalid");
   a_xstat_fixed: assert property (reg_rd_in && reg_addr_in == 5'h0f |=> reg_rdata_out == 16'h3000)
      else $error("xstat");
   a_mmd_rd_cause: assert property (mmd_rd_out |-> $past(reg_rd_in && reg_addr_in == 5'h0e))
      else $error("mmd rd");
   a_mmd_rd_data: assert property (mmd_rd_out |-> reg_rdata_out == $past(mmd_rdata_in)) else $error("rd data");
   a_mmd_wr_cause: assert property (mmd_wr_out |-> $past(reg_wr_in && reg_addr_in == 5'h0e)
      && mmd_wdata_out == $past(reg_wdata_in)) else $error("mmd wr");
   a_rdata_holds: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out)) else $error("rdata");
   a_xstat_wr_inert: assert property (reg_wr_in && reg_addr_in == 5'h0f |=> !mmd_wr_out && !mmd_rd_out)
      else $error("xstat wr");
   a_ctrl_res_zero: assert property (reg_rd_in && reg_addr_in == 5'h0d |=> reg_rdata_out[13:5] == 9'h0)
      else $error("ctrl res");
endmodule
bind mix_mmd_indirect mix_chk u_mix_chk (.*);
`default_nettype wire

//--- tb/mix_mc.sv
`timescale 1ns/1ps
`default_nettype none
// Station controller model driving the register port
module mix_mc
(
   input  wire logic        clk_sys_in,
   input  wire logic [15:0] reg_rdata_out,
   input  wire logic [15:0] mmd_rdata_in,
   output var  logic        reg_wr_in,
   output var  logic        reg_rd_in,
   output var  logic [4:0]  reg_addr_in,
   output var  logic [15:0] reg_wdata_in
);
   initial {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 23'h0;
   // One-cycle write; reserved control bits go out as zero
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= (a == 5'h0d) ? (d & 16'hc01f) : d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask
   // Read; m is the MMD word at the taking edge, reserved bits dropped
   task rd(input logic [4:0] a, output logic [15:0] d, output logic [15:0] m);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      m = mmd_rdata_in;
      #1;
      d = reg_rdata_out & ((a == 5'h0f) ? 16'hf000 : (a == 5'h0d) ? 16'hc01f : 16'hffff);
   endtask
endmodule
`default_nettype wire

//--- tb/test_mmd_indirect_access_xstat.sv
`timescale 1ns/1ps
`default_nettype none
module test_mmd_indirect_access_xstat;
   logic        clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out, mmd_wr_out, mmd_rd_out;
   logic [4:0]  reg_addr_in, mmd_device_select_out, dv;
   logic [15:0] reg_wdata_in, reg_rdata_out, mmd_reg_addr_out, mmd_wdata_out, mmd_rdata_in, a, b, d, m;
   integer      seed = 32'h7fa6, error_cnt = 0, n_checks = 0, t;
   mix_mmd_indirect u_mix_mmd_indirect (.*);
   mix_mc u_mix_mc (.*);
   // Clock, and a new MMD word each cycle so stale samples show
   initial
   begin
      {clk_sys_in, rst_n_in, mmd_rdata_in} = 18'h0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) mmd_rdata_in <= $random(seed);
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_checks = n_checks + 1;
      if (s !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Address moves from one read then one write per type
   function logic [15:0] bump(input integer k);
      bump = (k == 2) ? 16'h2 : (k == 3) ? 16'h1 : 16'h0;
   endfunction
   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      u_mix_mc.wr(5'h0f, 16'hffff);
      u_mix_mc.rd(5'h0f, d, m);
      chk(d, 16'h3000);
      b = $random(seed);
      u_mix_mc.wr(5'h0d, 16'h001f);
      u_mix_mc.wr(5'h0e, b);
      for (t = 1; t < 4; t = t + 1)
      begin
         dv = {$random(seed)} % 31;
         a = $random(seed);
         u_mix_mc.wr(5'h0d, {2'h0, 9'h1ff, dv});
         u_mix_mc.wr(5'h0e, a);
         u_mix_mc.wr(5'h0d, {t[1:0], 9'h0, dv});
         u_mix_mc.rd(5'h0d, d, m);
         chk(d, {t[1:0], 9'h0, dv});
         u_mix_mc.rd(5'h0e, d, m);
         chk(d, m);
         chk({11'h0, mmd_device_select_out}, {11'h0, dv});
         chk(mmd_reg_addr_out, a);
         u_mix_mc.wr(5'h0e, ~a);
         chk(mmd_wdata_out, ~a);
         chk(mmd_reg_addr_out, a + ((t == 2) ? 16'h1 : 16'h0));
         u_mix_mc.wr(5'h0d, {2'h0, 9'h0, dv});
         u_mix_mc.rd(5'h0e, d, m);
         chk(d, a + bump(t));
         $display("type %0d done", t);
      end
      u_mix_mc.wr(5'h0d, 16'h001f);
      u_mix_mc.rd(5'h0e, d, m);
      chk(d, b);
      give_verdict;
   end
   // Watchdog far beyond the roughly eighty cycles needed
   initial
   begin
      repeat (3000) @(posedge clk_sys_in);
      error_cnt = error_cnt + 1;
      give_verdict;
   end
endmodule
`default_nettype wire
